// file: hdl/fcpwm_pkg.sv
/*
 * package for the four-channel wave generator: register offsets, field
 * positions, reset values and clock-select codes.
 * assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package fcpwm_pkg;
   localparam int NUM_CH = 4;
   localparam int CNT_W  = 16;
   localparam int NUM_PRE = 11;

   // common registers, byte addresses
   localparam logic [11:0] OFS_GEN_MODE   = 12'h000;
   localparam logic [11:0] OFS_ENABLE     = 12'h004;
   localparam logic [11:0] OFS_DISABLE    = 12'h008;
   localparam logic [11:0] OFS_CH_STATUS  = 12'h00C;
   localparam logic [11:0] OFS_IRQ_EN     = 12'h010;
   localparam logic [11:0] OFS_IRQ_DIS    = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK   = 12'h018;
   localparam logic [11:0] OFS_PER_STATUS = 12'h01C;
   // per-channel block
   localparam logic [11:0] OFS_CH_BASE    = 12'h200;
   localparam int          CH_STRIDE_LSB  = 5;
   localparam logic [4:0]  OFS_CH_MODE    = 5'h00;
   localparam logic [4:0]  OFS_CH_DUTY    = 5'h04;
   localparam logic [4:0]  OFS_CH_PERIOD  = 5'h08;
   localparam logic [4:0]  OFS_CH_COUNT   = 5'h0C;
   localparam logic [4:0]  OFS_CH_UPDATE  = 5'h10;

   // generator mode field positions
   localparam int GM_DIVIDER_A_FACTOR_LSB = 0;
   localparam int GM_DIVIDER_A_SOURCE_SEL_LSB = 8;
   localparam int GM_DIVIDER_B_FACTOR_LSB = 16;
   localparam int GM_DIVIDER_B_SOURCE_SEL_LSB = 24;
   // channel mode field positions
   localparam int CM_SEL_LSB = 0;
   localparam int CM_ALG_BIT = 8;
   localparam int CM_POL_BIT = 9;
   localparam int CM_UPD_BIT = 10;

   // clock select codes above the prescaler taps
   localparam logic [3:0] CLK_SEL_A = 4'hB;
   localparam logic [3:0] CLK_SEL_B = 4'hC;

   // reset values
   localparam logic [31:0] RST_GEN_MODE = 32'h00000000;
   localparam logic [10:0] RST_CH_MODE  = 11'h000;
   localparam logic [15:0] RST_COUNT    = 16'h0000;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      FCPWM_UP   = 2'b01,
      FCPWM_DOWN = 2'b10
   } fcpwm_dir_t;
endpackage : fcpwm_pkg

// file: hdl/fcpwm_top.sv
/*
 * four-channel pulse width generator with AXI4-Lite register slave.
 * assumes one clock aclk and a synchronous active-low reset; slower
 * channel clocks are one-cycle enables; outputs go to a pin mux.
 */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
// Summary of operation
// - four channels, one waveform output each
// - each channel owns a 16-bit counter
// - prescaler gives master clock divided 1..1024
// - two linear dividers, thirteen clocks total
// - divider input chosen by its own select
// - select and factor reset zero; zero stops
// - all prescaler taps run at reset, dividers stopped
// - per-channel clock select, reset zero
// - counter direction from mode and compares
// - comparator derives output level from config
// - period or duty double-buffered per channel
// - one enable write starts channels together
// - enable and disable per channel independently
// - left or center alignment per channel
// - polarity sets level at period start
// - period value per channel, independent
// - left period is period times prescale
// - registers readable with clock stopped
// - writable with clock stopped; duty, period, mode except update select only while channel disabled
// - clock stop resumes exact previous state
// - all access through bus slave, level irq
// - center counts up then down; left restarts
// - update value loads at period end
// - period end sets flag, read clears
// - default polarity starts period low
`timescale 1ns/10ps
`default_nettype none
module fcpwm_top
   import fcpwm_pkg::*;
#(
   parameter int N_CH = fcpwm_pkg::NUM_CH     // channel count
) (
   input  wire logic              aclk,        // master clock
   input  wire logic              aresetn,     // sync reset, low
   input  wire logic [11:0]       s_awaddr,    // write address
   input  wire logic              s_awvalid,   // write address valid
   output logic                   s_awready,   // write address ready
   input  wire logic [31:0]       s_wdata,     // write data
   input  wire logic [3:0]        s_wstrb,     // byte enables
   input  wire logic              s_wvalid,    // write data valid
   output logic                   s_wready,    // write data ready
   output logic [1:0]             s_bresp,     // write response
   output logic                   s_bvalid,    // write response valid
   input  wire logic              s_bready,    // write response ready
   input  wire logic [11:0]       s_araddr,    // read address
   input  wire logic              s_arvalid,   // read address valid
   output logic                   s_arready,   // read address ready
   output logic [31:0]            s_rdata,     // read data
   output logic [1:0]             s_rresp,     // read response
   output logic                   s_rvalid,    // read data valid
   input  wire logic              s_rready,    // read data ready
   output logic                   irq,         // level interrupt
   output logic [N_CH-1:0]        wave_out_n   // channel waveforms
);
   import fcpwm_pkg::*;

   // apply byte enables to an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            old[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return old;
   endfunction : merge

   // state
   logic [31:0]            generator_mode_reg;
   logic [N_CH-1:0]        ch_enabled;
   logic [N_CH-1:0]        irq_mask;
   logic [N_CH-1:0]        period_status_reg;
   logic [10:0]            channel_mode_reg [N_CH];
   logic [CNT_W-1:0]       duty_value       [N_CH];
   logic [CNT_W-1:0]       period_value     [N_CH];
   logic [CNT_W-1:0]       update_value     [N_CH];
   logic [N_CH-1:0]        upd_pending;
   logic [CNT_W-1:0]       count            [N_CH];
   fcpwm_dir_t             dir              [N_CH];
   logic [9:0]             pre_cnt;
   logic [7:0]             div_a_cnt, div_b_cnt;
   logic                   divided_clock_a, divided_clock_b;

   // generator fields
   wire [7:0] divider_a_factor     = generator_mode_reg[GM_DIVIDER_A_FACTOR_LSB +: 8];
   wire [3:0] divider_a_source_sel = generator_mode_reg[GM_DIVIDER_A_SOURCE_SEL_LSB +: 4];
   wire [7:0] divider_b_factor     = generator_mode_reg[GM_DIVIDER_B_FACTOR_LSB +: 8];
   wire [3:0] divider_b_source_sel = generator_mode_reg[GM_DIVIDER_B_SOURCE_SEL_LSB +: 4];

   // prescaler taps: tap k pulses once every 2**k cycles
   wire [NUM_PRE-1:0] pre_tick;
   assign pre_tick[0] = 1'b1;
   genvar gk;
   generate
      for (gk = 1; gk < NUM_PRE; gk++) begin : g_tap
         assign pre_tick[gk] = (pre_cnt[gk-1:0] == '1);
      end
   endgenerate

   // linear divider source taps
   wire src_a = (divider_a_source_sel < 4'(NUM_PRE)) ? pre_tick[divider_a_source_sel] : 1'b0;
   wire src_b = (divider_b_source_sel < 4'(NUM_PRE)) ? pre_tick[divider_b_source_sel] : 1'b0;
   wire tick_a = src_a && (divider_a_factor != 8'h00)
                 && (div_a_cnt >= divider_a_factor - 8'h01);
   wire tick_b = src_b && (divider_b_factor != 8'h00)
                 && (div_b_cnt >= divider_b_factor - 8'h01);

   // prescaler counter and dividers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= '0;
         div_a_cnt <= 8'h00;
         div_b_cnt <= 8'h00;
         divided_clock_a <= 1'b0;
         divided_clock_b <= 1'b0;
      end else begin
         pre_cnt <= pre_cnt + 10'h001;
         // a factor lowered below the count restarts at the next tick
         if (src_a) begin
            div_a_cnt <= tick_a ? 8'h00 : div_a_cnt + 8'h01;
         end
         if (src_b) begin
            div_b_cnt <= tick_b ? 8'h00 : div_b_cnt + 8'h01;
         end
         divided_clock_a <= tick_a;
         divided_clock_b <= tick_b;
      end
   end

   // bus handshake
   logic aw_got, w_got;
   logic [11:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   wire do_write = aw_got && w_got && !s_bvalid;
   wire [11:0] wa = aw_addr_q;
   wire [11:0] ra = s_araddr;
   wire do_read = s_arvalid && s_arready;

   // per-channel address decode
   function automatic logic ch_hit(input logic [11:0] a, input int c, input logic [4:0] o);
      return (a[11:9] == 3'b001) && (a[8:5] == 4'(c)) && (a[4:0] == o);
   endfunction : ch_hit

   wire wr_gen = do_write && (wa == OFS_GEN_MODE);
   wire wr_ena = do_write && (wa == OFS_ENABLE);
   wire wr_dis = do_write && (wa == OFS_DISABLE);
   wire wr_ien = do_write && (wa == OFS_IRQ_EN);
   wire wr_idi = do_write && (wa == OFS_IRQ_DIS);
   wire rd_psr = do_read && (ra == OFS_PER_STATUS);

   // channel logic
   wire [N_CH-1:0] period_end;
   generate
      for (gk = 0; gk < N_CH; gk++) begin : g_ch
         wire [3:0] channel_clock_sel = channel_mode_reg[gk][CM_SEL_LSB +: 4];
         wire alignment_sel     = channel_mode_reg[gk][CM_ALG_BIT];
         wire output_polarity   = channel_mode_reg[gk][CM_POL_BIT];
         wire update_target_sel = channel_mode_reg[gk][CM_UPD_BIT];
         // clock selection
         wire ce = (channel_clock_sel < 4'(NUM_PRE)) ? pre_tick[channel_clock_sel] :
                   (channel_clock_sel == CLK_SEL_A) ? divided_clock_a :
                   (channel_clock_sel == CLK_SEL_B) ? divided_clock_b : 1'b0;
         wire step = ch_enabled[gk] && ce;
         // end of period: left at top, center at zero on the way down
         wire at_top = (count[gk] >= period_value[gk] - 16'h0001);   // period_value steps
         wire at_end = alignment_sel ? (dir[gk] == FCPWM_DOWN && count[gk] <= 16'h0001)
                                     : at_top;
         assign period_end[gk] = step && at_end;
         wire mode_wr = do_write && ch_hit(wa, gk, OFS_CH_MODE);
         wire duty_wr = do_write && ch_hit(wa, gk, OFS_CH_DUTY);
         wire per_wr  = do_write && ch_hit(wa, gk, OFS_CH_PERIOD);
         wire upd_wr  = do_write && ch_hit(wa, gk, OFS_CH_UPDATE);
         // level: start level below period minus duty, opposite once reached
         wire below = (count[gk] < (period_value[gk] - duty_value[gk]));
         wire level = below ? output_polarity : ~output_polarity;

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               channel_mode_reg[gk] <= RST_CH_MODE;
               duty_value[gk] <= RST_COUNT;
               period_value[gk] <= RST_COUNT;
               update_value[gk] <= RST_COUNT;
               upd_pending[gk] <= 1'b0;
               count[gk] <= RST_COUNT;
               dir[gk] <= FCPWM_UP;
               wave_out_n[gk] <= 1'b0;
            end else begin
               // polarity and alignment only while disabled
               if (mode_wr && !ch_enabled[gk]) begin
                  channel_mode_reg[gk] <= 11'(merge(32'(channel_mode_reg[gk]), w_data_q,
                                                    w_strb_q));
               end else if (mode_wr) begin
                  channel_mode_reg[gk][CM_UPD_BIT] <= w_data_q[CM_UPD_BIT];
               end
               if (duty_wr && !ch_enabled[gk]) duty_value[gk] <= w_data_q[15:0];
               if (per_wr && !ch_enabled[gk]) period_value[gk] <= w_data_q[15:0];
               // buffered update, taken at period end
               if (upd_wr) begin
                  update_value[gk] <= w_data_q[15:0];
                  upd_pending[gk] <= 1'b1;
               end else if (period_end[gk] && upd_pending[gk]) begin
                  upd_pending[gk] <= 1'b0;
               end
               if (period_end[gk] && upd_pending[gk]) begin
                  if (update_target_sel) period_value[gk] <= update_value[gk];
                  else duty_value[gk] <= update_value[gk];
               end
               // counter: holds while not stepped; clock gaps resume where stopped, enabling from idle restarts at zero
               if (wr_ena && w_data_q[gk] && !ch_enabled[gk]) begin
                  count[gk] <= RST_COUNT;
                  dir[gk] <= FCPWM_UP;
               end else if (step) begin
                  if (!alignment_sel) begin
                     count[gk] <= at_top ? RST_COUNT : count[gk] + 16'h0001;
                  end else if (dir[gk] == FCPWM_UP) begin
                     if (count[gk] + 16'h0001 >= period_value[gk]) dir[gk] <= FCPWM_DOWN;
                     count[gk] <= count[gk] + 16'h0001;
                  end else begin
                     if (count[gk] <= 16'h0001) dir[gk] <= FCPWM_UP;
                     count[gk] <= count[gk] - 16'h0001;
                  end
               end
               wave_out_n[gk] <= ch_enabled[gk] ? level : output_polarity;
            end
         end
      end
   endgenerate

   // common registers, write side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         generator_mode_reg <= RST_GEN_MODE;
         ch_enabled <= '0;
         irq_mask <= '0;
         period_status_reg <= '0;
      end else begin
         if (wr_gen) generator_mode_reg <= merge(generator_mode_reg, w_data_q, w_strb_q);
         ch_enabled <= (ch_enabled | (wr_ena ? w_data_q[N_CH-1:0] : '0))
                       & ~(wr_dis ? w_data_q[N_CH-1:0] : '0);
         irq_mask <= (irq_mask | (wr_ien ? w_data_q[N_CH-1:0] : '0))
                     & ~(wr_idi ? w_data_q[N_CH-1:0] : '0);
         // new period end wins over the read clear
         period_status_reg <= (rd_psr ? '0 : period_status_reg) | period_end;
      end
   end

   // read mux; enable, disable, irq enable and irq disable read as zero
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h00000000;
      case (ra)
         OFS_GEN_MODE:   rmux = generator_mode_reg;
         OFS_CH_STATUS:  rmux = 32'(ch_enabled);
         OFS_IRQ_MASK:   rmux = 32'(irq_mask);
         OFS_PER_STATUS: rmux = 32'(period_status_reg);
         default: begin
            for (int c = 0; c < N_CH; c++) begin
               if (ch_hit(ra, c, OFS_CH_MODE))   rmux = 32'(channel_mode_reg[c]);
               if (ch_hit(ra, c, OFS_CH_DUTY))   rmux = 32'(duty_value[c]);
               if (ch_hit(ra, c, OFS_CH_PERIOD)) rmux = 32'(period_value[c]);
               if (ch_hit(ra, c, OFS_CH_COUNT))  rmux = 32'(count[c]);
               if (ch_hit(ra, c, OFS_CH_UPDATE)) rmux = 32'(update_value[c]);
            end
         end
      endcase
   end

   // AXI4-Lite slave channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr_q <= 12'h000;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= RESP_OKAY;
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h00000000;
         s_rresp <= RESP_OKAY;
         irq <= 1'b0;
      end else begin
         s_awready <= !aw_got && !s_awready && !s_bvalid;
         s_wready <= !w_got && !s_wready && !s_bvalid;
         if (s_awvalid && s_awready) begin
            aw_got <= 1'b1;
            aw_addr_q <= {s_awaddr[11:2], 2'b00};
         end
         if (s_wvalid && s_wready) begin
            w_got <= 1'b1;
            w_data_q <= s_wdata;
            w_strb_q <= s_wstrb;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= RESP_OKAY;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
         s_arready <= !s_arready && !s_rvalid && s_arvalid;
         if (do_read) begin
            s_rvalid <= 1'b1;
            s_rdata <= rmux;
            s_rresp <= RESP_OKAY;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
         irq <= |(period_status_reg & irq_mask);
      end
   end

   // checks
   a_stat_set: assert property (@(posedge aclk) disable iff (!aresetn)
      period_end[0] |=> period_status_reg[0]) else $error("period flag not set");
   a_div_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      (divider_a_factor == 8'h00) |=> !divided_clock_a) else $error("divider a ran at zero");
   a_cnt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !ch_enabled[0] && !wr_ena |=> $stable(count[0])) else $error("count moved while off");
   a_left_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      period_end[0] && !channel_mode_reg[0][CM_ALG_BIT] |=> count[0] == 16'h0000)
      else $error("left count did not restart");
   a_ena_start: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_ena && w_data_q[0] |=> ch_enabled[0]) else $error("enable ignored");
   a_dis_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dis && w_data_q[1] && !wr_ena |=> !ch_enabled[1]) else $error("disable ignored");
   a_tap_one: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_tick[1] |=> !pre_tick[1]) else $error("half tap too fast");
   a_irq_lvl: assert property (@(posedge aclk) disable iff (!aresetn)
      period_status_reg[0] && irq_mask[0] |=> irq) else $error("irq missing");
   // enabling an idle channel restarts it from zero
   sequence s_start0;
      wr_ena && w_data_q[0] && !ch_enabled[0];
   endsequence
   a_ena_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_start0 |=> count[0] == RST_COUNT && dir[0] == FCPWM_UP)
      else $error("enable kept old count");
   // a disabled channel shows its polarity level
   a_off_level: assert property (@(posedge aclk) disable iff (!aresetn)
      !ch_enabled[3] |=> wave_out_n[3] == $past(channel_mode_reg[3][CM_POL_BIT]))
      else $error("idle level not polarity");
   // a pending update lands at period end in the chosen register
   sequence s_load_per0;
      period_end[0] && upd_pending[0] && channel_mode_reg[0][CM_UPD_BIT];
   endsequence
   sequence s_load_duty0;
      period_end[0] && upd_pending[0] && !channel_mode_reg[0][CM_UPD_BIT];
   endsequence
   a_upd_per: assert property (@(posedge aclk) disable iff (!aresetn)
      s_load_per0 |=> period_value[0] == $past(update_value[0]))
      else $error("period update not applied");
   a_upd_duty: assert property (@(posedge aclk) disable iff (!aresetn)
      s_load_duty0 |=> duty_value[0] == $past(update_value[0]))
      else $error("duty update not applied");
   a_duty_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ch_enabled[0] && !period_end[0] |=> $stable(duty_value[0]))
      else $error("duty changed mid-period");
   // center period ends with the count back at zero
   a_ctr_turn: assert property (@(posedge aclk) disable iff (!aresetn)
      period_end[3] && channel_mode_reg[3][CM_ALG_BIT]
      |=> count[3] == RST_COUNT && dir[3] == FCPWM_UP) else $error("center end off zero");
   // at or past the duty threshold the level flips
   a_lvl_duty: assert property (@(posedge aclk) disable iff (!aresetn)
      ch_enabled[0] && (count[0] >= period_value[0] - duty_value[0])
      |=> wave_out_n[0] != $past(channel_mode_reg[0][CM_POL_BIT]))
      else $error("level did not flip");
endmodule : fcpwm_top
`default_nettype wire

// file: tb/fcpwm_axi_mst.sv
/* axi4-lite master model standing in for the processor.
   assumes the bench calls wr and rd one at a time. */
`timescale 1ns/10ps
`default_nettype none
module fcpwm_axi_mst (
   input  wire logic        aclk,      // bus clock
   output logic [11:0]      awaddr,    // write address
   output logic             awvalid,   // write address valid
   input  wire logic        awready,   // write address taken
   output logic [31:0]      wdata,     // write data
   output logic [3:0]       wstrb,     // byte enables
   output logic             wvalid,    // write data valid
   input  wire logic        wready,    // write data taken
   input  wire logic [1:0]  bresp,     // write response
   input  wire logic        bvalid,    // write response valid
   output logic             bready,    // write response ready
   output logic [11:0]      araddr,    // read address
   output logic             arvalid,   // read address valid
   input  wire logic        arready,   // read address taken
   input  wire logic [31:0] rdata,     // read data
   input  wire logic [1:0]  rresp,     // read response
   input  wire logic        rvalid,    // read data valid
   output logic             rready,    // read data ready
   output logic             timed_out  // an answer never came
);
   // idle bus at time zero
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready, timed_out} = '0;
   end

   // one write; each channel released when taken, address and data inverted after
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      r = bresp;
      bready <= 1'b0;
      awaddr <= ~a;
      wdata  <= ~d;
      if (n == 100) timed_out <= 1'b1;
   endtask : wr

   // one read; rready held until rvalid is seen
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      araddr <= ~a;
      if (n == 100) timed_out <= 1'b1;
   endtask : rd
endmodule : fcpwm_axi_mst
`default_nettype wire

// file: tb/tb_top.sv
/* self-checking bench for the four-channel wave generator.
   assumes the bus master model in fcpwm_axi_mst. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fcpwm_pkg::*;
   logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, irq, to;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdt;
   logic [3:0]  ws, wave_out_n;
   logic [1:0]  bre, rre;
   int          n_mismatch, check_count;

   fcpwm_top dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa), .s_awvalid(awv),
      .s_awready(awr), .s_wdata(wd), .s_wstrb(ws), .s_wvalid(wv), .s_wready(wr_),
      .s_bresp(bre), .s_bvalid(bv), .s_bready(br), .s_araddr(ara), .s_arvalid(arv),
      .s_arready(arr), .s_rdata(rdt), .s_rresp(rre), .s_rvalid(rv), .s_rready(rr),
      .irq(irq), .wave_out_n(wave_out_n));
   fcpwm_axi_mst mst (.aclk(aclk), .awaddr(awa), .awvalid(awv), .awready(awr),
      .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wr_), .bresp(bre), .bvalid(bv),
      .bready(br), .araddr(ara), .arvalid(arv), .arready(arr), .rdata(rdt),
      .rresp(rre), .rvalid(rv), .rready(rr), .timed_out(to));

   // 250 mhz clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic hang;
      n_mismatch++;
      end_of_test();
   endtask : hang

   // bus master gave up waiting
   always @(posedge aclk) if (to === 1'b1) hang();

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   function automatic logic [11:0] ca(input int ch, input logic [4:0] off);
      return OFS_CH_BASE + 12'(ch << CH_STRIDE_LSB) + {7'h00, off};
   endfunction : ca

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      mst.wr(a, d, 4'hF, r);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      mst.rd(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, RESP_OKAY});
   endtask : rdc

   // set up one channel and enable it
   task automatic chan(input int ch, input logic [31:0] mode, input logic [15:0] per,
                       input logic [15:0] duty);
      wr(OFS_DISABLE, 32'h1 << ch);
      wr(ca(ch, OFS_CH_MODE), mode);
      wr(ca(ch, OFS_CH_PERIOD), {16'h0, per});
      wr(ca(ch, OFS_CH_DUTY), {16'h0, duty});
      wr(OFS_ENABLE, 32'h1 << ch);
   endtask : chan

   // cycles from a rising edge to the fall, and to the next rise
   task automatic measure(input int ch, output int hi, output int per);
      int n;
      n = 0;
      hi = 0;
      per = 0;
      while (wave_out_n[ch] !== 1'b0 && n < 5000) begin @(posedge aclk); n++; end
      while (wave_out_n[ch] !== 1'b1 && n < 5000) begin @(posedge aclk); n++; end
      while (wave_out_n[ch] === 1'b1 && n < 5000) begin @(posedge aclk); hi++; n++; end
      while (wave_out_n[ch] === 1'b0 && n < 5000) begin @(posedge aclk); per++; n++; end
      per += hi;
      if (n >= 5000) hang();
   endtask : measure

   task automatic t_reset;
      logic [11:0] am[9];
      logic [1:0]  r;
      am = '{OFS_GEN_MODE, OFS_CH_STATUS, OFS_IRQ_MASK, OFS_PER_STATUS, 12'h200, 12'h204,
             12'h208, 12'h20C, 12'h020};
      foreach (am[i]) rdc(am[i], 32'h0);
      mst.wr(OFS_GEN_MODE, 32'h0C050A03, 4'h5, r);
      rdc(OFS_GEN_MODE, 32'h00050003);
      $display("test reset done");
   endtask : t_reset

   task automatic t_taps;
      int hi, per;
      for (int k = 0; k < NUM_PRE; k++) begin
         chan(0, k, 16'h2, 16'h1);
         measure(0, hi, per);
         check(per, 2 << k);
         check(hi, 1 << k);
      end
      $display("test taps done");
   endtask : t_taps

   task automatic t_div;
      int hi, per;
      wr(OFS_GEN_MODE, 32'h00020103);
      chan(1, CLK_SEL_A, 16'h4, 16'h1);
      measure(1, hi, per);
      check(per, 24);
      check(hi, 6);
      chan(2, CLK_SEL_B, 16'h5, 16'h2);
      measure(2, hi, per);
      check(per, 10);
      check(hi, 4);
      wr(OFS_GEN_MODE, 32'h0);
      chan(1, CLK_SEL_A, 16'h5, 16'h1);
      repeat (50) @(posedge aclk);
      rdc(ca(1, OFS_CH_COUNT), 32'h0);
      $display("test dividers done");
   endtask : t_div

   task automatic t_shape;
      int hi, per;
      chan(3, 32'h100, 16'h6, 16'h2);
      measure(3, hi, per);
      check(per, 12);
      wr(OFS_DISABLE, 32'h8);
      wr(ca(3, OFS_CH_MODE), 32'h200);
      repeat (3) @(posedge aclk);
      check(wave_out_n[3], 1'b1);
      chan(3, 32'h200, 16'hA, 16'h3);
      measure(3, hi, per);
      check(hi, 7);
      check(per, 10);
      $display("test shape done");
   endtask : t_shape

   task automatic t_sync;
      int hi, per;
      wr(OFS_DISABLE, 32'hF);
      rdc(OFS_CH_STATUS, 32'h0);
      wr(OFS_ENABLE, 32'hF);
      rdc(OFS_CH_STATUS, 32'hF);
      wr(OFS_DISABLE, 32'h2);
      rdc(OFS_CH_STATUS, 32'hD);
      measure(3, hi, per);
      check(per, 10);
      $display("test sync done");
   endtask : t_sync

   task automatic t_upd;
      int hi, per;
      wr(OFS_DISABLE, 32'hF);
      chan(0, 32'h0, 16'hA, 16'h3);
      wr(ca(0, OFS_CH_DUTY), 32'h7);
      measure(0, hi, per);
      measure(0, hi, per);
      check(hi, 3);
      wr(ca(0, OFS_CH_UPDATE), 32'h6);
      measure(0, hi, per);
      measure(0, hi, per);
      check(hi, 6);
      wr(ca(0, OFS_CH_MODE), 32'h400);
      wr(ca(0, OFS_CH_UPDATE), 32'h14);
      measure(0, hi, per);
      measure(0, hi, per);
      check(per, 20);
      $display("test update done");
   endtask : t_upd

   task automatic t_irq;
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      mst.rd(OFS_PER_STATUS, d, r);
      wr(OFS_IRQ_EN, 32'h1);
      rdc(OFS_IRQ_MASK, 32'h1);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge aclk);
      check(irq, 1'b1);
      rdc(OFS_PER_STATUS, 32'h1);
      wr(OFS_IRQ_DIS, 32'h1);
      rdc(OFS_IRQ_MASK, 32'h0);
      repeat (3) @(posedge aclk);
      check(irq, 1'b0);
      $display("test interrupt done");
   endtask : t_irq

   // reset, then every scenario in turn
   initial begin
      n_mismatch = 0;
      check_count = 0;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      check(wave_out_n, 4'h0);
      t_reset();
      t_taps();
      t_div();
      t_shape();
      t_sync();
      t_upd();
      t_irq();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
